// *** logic/pwc_pkg.sv ***
// Constants shared by the pin and wake error configuration register bank.
package pwc_pkg;
  localparam logic [6:0] ADDR_PIN_CFG = 7'h1A;
  localparam logic [6:0] ADDR_WAKE_CFG = 7'h1B;
  localparam logic [6:0] ADDR_TIMER_CFG = 7'h1C;
  localparam logic [6:0] ADDR_SDO_CFG = 7'h29;
  localparam int BIT_SUPPLY_DIS = 6;
  localparam int BIT_FUNC_SEL = 5;
  localparam int BIT_FB_DIS = 4;
  localparam int BIT_METHOD_HI = 3;
  localparam int BIT_METHOD_LO = 2;
  localparam int BIT_FB_STROBE = 1;
  localparam int BIT_WAKE_MAX_OFF = 1;
  localparam int BIT_TIMER_OFF = 7;
  localparam int BIT_SILENCE_OFF = 2;
  localparam int BIT_SDO_MODE = 0;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [7:0] RST_WAKE_CFG = 8'h00;
  localparam logic [7:0] RST_TIMER_CFG = 8'h04;
  localparam logic [7:0] RST_SDO_CFG = 8'h00;
  localparam logic [1:0] METHOD_THIRD = 2'h0;
  localparam logic [1:0] METHOD_FIRST = 2'h1;
  localparam logic [1:0] METHOD_STROBE = 2'h2;
  localparam logic [1:0] TRIG_COUNT_OFF = 2'h3;
  localparam logic [4:0] BITS_HEADER = 5'h08;
  localparam logic [4:0] BITS_FRAME = 5'h10;
  localparam int CLK_HZ = 40_000_000;
  localparam int WAKE_WINDOW_US = 1000;
  localparam int WAKE_WINDOW_CYC = (WAKE_WINDOW_US * (CLK_HZ / 1_000_000));
endpackage : pwc_pkg

// *** logic/pwc_regs.sv ***
// Serial-accessed configuration bank for the shared supply and fallback pin and the wake timer.
`timescale 1ns/1ps
module pwc_regs #(
  parameter bit HAS_FALLBACK = 1'b1,
  parameter int WAKE_TIMER_CYCLES = pwc_pkg::WAKE_WINDOW_CYC
) (
  input wire logic clk_i, // System clock, 40 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic sclk_i, // Serial clock pin.
  input wire logic cs_n_i, // Serial chip select pin, active low.
  input wire logic sdi_i, // Serial data in pin.
  input wire logic io_supply_pin_i, // High while the I/O supply is present.
  input wire logic interrupt_out_n_i, // Interrupt level to share on the serial out pin.
  input wire logic wd_good_trigger_i, // One-cycle pulse per correct watchdog trigger.
  input wire logic fallback_fault_i, // One-cycle pulse that switches the fallback output on.
  input wire logic wake_exit_i, // One-cycle pulse on leaving sleep through a wake event.
  input wire logic bus_silence_flag_i, // Bus silence flag level.
  output logic sdo_o, // Serial data out pin level.
  output logic sdo_oe_o, // Serial data out pin drive enable.
  output logic supply_enable_output_o, // Shared pin level, supply-enable function.
  output logic fallback_output_o, // Shared pin level, fallback function.
  output logic wake_max_pulse_check_off_o, // Wake maximum width check dropped.
  output logic wake_timer_running_o, // Sleep-wake-error timer running.
  output logic sleep_return_o // One-cycle pulse: go back to sleep.
);
  if (WAKE_TIMER_CYCLES < 2 || WAKE_TIMER_CYCLES > 32'h0FFF_FFFF) begin : g_bad_cycles
    $error("WAKE_TIMER_CYCLES out of range.");
  end

  logic sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_s2_q, sdi_s1_q, sdi_s2_q, io_s1_q, io_s2_q;
  logic [4:0] bits_q, bits_d;
  logic [7:0] sin_q, sin_d, sout_q, sout_d, hdr_q, hdr_d;
  logic [7:0] pin_q, pin_d, wake_q, wake_d, tmr_q, tmr_d, sdoc_q, sdoc_d;
  logic fb_on_q, fb_on_d;
  logic [1:0] trig_q, trig_d;
  logic [27:0] cnt_q, cnt_d;
  logic run_q, run_d, sleep_q, sleep_d, sdo_q, sdo_d, oe_q, oe_d, sup_q, sup_d, fbo_q, fbo_d;
  logic active, rise, fall, frame_done, wr, strobe, fb_off;
  logic [7:0] shifted, rdata;

  always_ff @(posedge clk_i) begin
    sclk_s1_q <= sclk_i;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    cs_s1_q <= cs_n_i;
    cs_s2_q <= cs_s1_q;
    sdi_s1_q <= sdi_i;
    sdi_s2_q <= sdi_s1_q;
    io_s1_q <= io_supply_pin_i;
    io_s2_q <= io_s1_q;
  end

  // The serial port only needs the I/O supply, so it keeps working in sleep.
  assign active = !cs_s2_q && io_s2_q;
  assign rise = active && sclk_s2_q && !sclk_s3_q;
  assign fall = active && !sclk_s2_q && sclk_s3_q;
  assign shifted = {sin_q[6:0], sdi_s2_q};
  assign frame_done = rise && (bits_q == pwc_pkg::BITS_FRAME - 5'h01);
  assign wr = frame_done && hdr_q[0];

  always_comb begin
    unique case (hdr_q[7:1])
      pwc_pkg::ADDR_PIN_CFG: rdata = pin_q;
      pwc_pkg::ADDR_WAKE_CFG: rdata = wake_q;
      pwc_pkg::ADDR_TIMER_CFG: rdata = tmr_q;
      pwc_pkg::ADDR_SDO_CFG: rdata = sdoc_q;
      default: rdata = 8'h00;
    endcase
  end

  // Frame: header byte of address (7 bits) and write flag, then one data byte, MSB first.
  always_comb begin
    bits_d = bits_q;
    sin_d = sin_q;
    hdr_d = hdr_q;
    sout_d = sout_q;
    if (!active) begin
      bits_d = 5'h00;
    end else if (rise) begin
      sin_d = shifted;
      bits_d = frame_done ? 5'h00 : bits_q + 5'h01;
      if (bits_q == pwc_pkg::BITS_HEADER - 5'h01) begin
        hdr_d = shifted;
        sout_d = 8'h00;
      end
    end else if (fall && bits_q == pwc_pkg::BITS_HEADER) begin
      sout_d = rdata;
    end else if (fall && bits_q > pwc_pkg::BITS_HEADER) begin
      sout_d = {sout_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits_q <= 5'h00;
      sin_q <= 8'h00;
      hdr_q <= 8'h00;
      sout_q <= 8'h00;
    end else begin
      bits_q <= bits_d;
      sin_q <= sin_d;
      hdr_q <= hdr_d;
      sout_q <= sout_d;
    end
  end

  // Register writes keep only the defined bits.
  always_comb begin
    pin_d = pin_q;
    wake_d = wake_q;
    tmr_d = tmr_q;
    sdoc_d = sdoc_q;
    strobe = 1'b0;
    if (wr) begin
      unique case (hdr_q[7:1])
        pwc_pkg::ADDR_PIN_CFG: begin
          pin_d = 8'h00;
          pin_d[pwc_pkg::BIT_SUPPLY_DIS] = shifted[pwc_pkg::BIT_SUPPLY_DIS];
          if (HAS_FALLBACK) begin
            pin_d[pwc_pkg::BIT_FUNC_SEL] = shifted[pwc_pkg::BIT_FUNC_SEL];
            pin_d[pwc_pkg::BIT_FB_DIS] = shifted[pwc_pkg::BIT_FB_DIS];
            pin_d[pwc_pkg::BIT_METHOD_HI] = shifted[pwc_pkg::BIT_METHOD_HI];
            pin_d[pwc_pkg::BIT_METHOD_LO] = shifted[pwc_pkg::BIT_METHOD_LO];
            strobe = shifted[pwc_pkg::BIT_FB_STROBE];
          end
        end
        pwc_pkg::ADDR_WAKE_CFG: begin
          wake_d = 8'h00;
          wake_d[pwc_pkg::BIT_WAKE_MAX_OFF] = shifted[pwc_pkg::BIT_WAKE_MAX_OFF];
        end
        pwc_pkg::ADDR_TIMER_CFG: begin
          tmr_d = 8'h00;
          tmr_d[pwc_pkg::BIT_TIMER_OFF] = shifted[pwc_pkg::BIT_TIMER_OFF];
          tmr_d[pwc_pkg::BIT_SILENCE_OFF] = shifted[pwc_pkg::BIT_SILENCE_OFF];
        end
        pwc_pkg::ADDR_SDO_CFG: begin
          sdoc_d = 8'h00;
          sdoc_d[pwc_pkg::BIT_SDO_MODE] = shifted[pwc_pkg::BIT_SDO_MODE];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= pwc_pkg::RST_PIN_CFG;
      wake_q <= pwc_pkg::RST_WAKE_CFG;
      tmr_q <= pwc_pkg::RST_TIMER_CFG;
      sdoc_q <= pwc_pkg::RST_SDO_CFG;
    end else begin
      pin_q <= pin_d;
      wake_q <= wake_d;
      tmr_q <= tmr_d;
      sdoc_q <= sdoc_d;
    end
  end

  // Fallback output: a fault switches it on and wins over a turn-off in the same cycle.
  always_comb begin
    unique case (pin_q[pwc_pkg::BIT_METHOD_HI:pwc_pkg::BIT_METHOD_LO])
      pwc_pkg::METHOD_THIRD: fb_off = wd_good_trigger_i && trig_q == pwc_pkg::TRIG_COUNT_OFF - 2'h1;
      pwc_pkg::METHOD_FIRST: fb_off = wd_good_trigger_i;
      default: fb_off = 1'b0;
    endcase
    // The strobe obeys the method written with it, so one write can select the method and fire it.
    if (strobe && pin_d[pwc_pkg::BIT_METHOD_HI:pwc_pkg::BIT_METHOD_LO] == pwc_pkg::METHOD_STROBE) begin
      fb_off = 1'b1;
    end
    fb_on_d = fb_on_q;
    trig_d = trig_q;
    if (fallback_fault_i && HAS_FALLBACK) begin
      fb_on_d = 1'b1;
      trig_d = 2'h0;
    end else if (fb_off) begin
      fb_on_d = 1'b0;
      trig_d = 2'h0;
    end else if (fb_on_q && wd_good_trigger_i && trig_q != pwc_pkg::TRIG_COUNT_OFF) begin
      trig_d = trig_q + 2'h1;
    end
    sup_d = !pin_q[pwc_pkg::BIT_FUNC_SEL] && !pin_q[pwc_pkg::BIT_SUPPLY_DIS];
    fbo_d = pin_q[pwc_pkg::BIT_FUNC_SEL] && !pin_q[pwc_pkg::BIT_FB_DIS] && fb_on_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fb_on_q <= 1'b0;
      trig_q <= 2'h0;
      sup_q <= 1'b0;
      fbo_q <= 1'b0;
    end else begin
      fb_on_q <= fb_on_d;
      trig_q <= trig_d;
      sup_q <= sup_d;
      fbo_q <= fbo_d;
    end
  end

  // Sleep-wake-error timer; any completed serial frame stops it.
  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    sleep_d = 1'b0;
    if (run_q) begin
      if (frame_done) begin
        run_d = 1'b0;
      end else if (!tmr_q[pwc_pkg::BIT_SILENCE_OFF] && !bus_silence_flag_i) begin
        cnt_d = 28'h0;
      end else if (cnt_q == 28'(WAKE_TIMER_CYCLES - 1)) begin
        run_d = 1'b0;
        sleep_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 28'h1;
      end
    end else if (wake_exit_i && !tmr_q[pwc_pkg::BIT_TIMER_OFF]) begin
      run_d = 1'b1;
      cnt_d = 28'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b1;
      cnt_q <= 28'h0;
      sleep_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      sleep_q <= sleep_d;
    end
  end

  // Serial out pin sharing with the interrupt level.
  always_comb begin
    oe_d = active || (io_s2_q && sdoc_q[pwc_pkg::BIT_SDO_MODE]);
    sdo_d = active ? sout_q[7] : (sdoc_q[pwc_pkg::BIT_SDO_MODE] && interrupt_out_n_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = oe_q;
  assign supply_enable_output_o = sup_q;
  assign fallback_output_o = fbo_q;
  assign wake_max_pulse_check_off_o = wake_q[pwc_pkg::BIT_WAKE_MAX_OFF];
  assign wake_timer_running_o = run_q;
  assign sleep_return_o = sleep_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence frame_write_s;
    wr;
  endsequence
  sequence strobe_write_s;
    frame_write_s ##0 (hdr_q[7:1] == pwc_pkg::ADDR_PIN_CFG && shifted[pwc_pkg::BIT_FB_STROBE] && !fallback_fault_i
      && shifted[pwc_pkg::BIT_METHOD_HI:pwc_pkg::BIT_METHOD_LO] == pwc_pkg::METHOD_STROBE);
  endsequence
  supply_disable_a: assert property (pin_q[pwc_pkg::BIT_SUPPLY_DIS] |=> !supply_enable_output_o)
    else $error("Supply output on while disabled.");
  func_select_a: assert property (pin_q[pwc_pkg::BIT_FUNC_SEL] |=> !supply_enable_output_o)
    else $error("Supply output on with fallback selected.");
  fallback_disable_a: assert property (pin_q[pwc_pkg::BIT_FB_DIS] |=> !fallback_output_o)
    else $error("Fallback output on while disabled.");
  first_trigger_off_a: assert property (pin_q[pwc_pkg::BIT_METHOD_HI:pwc_pkg::BIT_METHOD_LO]
    == pwc_pkg::METHOD_FIRST && wd_good_trigger_i && !fallback_fault_i |=> !fb_on_q)
    else $error("First trigger did not turn fallback off.");
  strobe_readback_a: assert property (frame_write_s |=> !pin_q[pwc_pkg::BIT_FB_STROBE])
    else $error("Fallback strobe bit read back set.");
  strobe_off_a: assert property (strobe_write_s |=> !fb_on_q)
    else $error("Fallback strobe did not turn fallback off.");
  timer_reset_value_a: assert property ($past(rst_i) |-> tmr_q == pwc_pkg::RST_TIMER_CFG && run_q)
    else $error("Timer register or power-on start wrong after reset.");
  timer_start_block_a: assert property (!run_q && tmr_q[pwc_pkg::BIT_TIMER_OFF] |=> !run_q)
    else $error("Timer started while disabled.");
  access_stops_a: assert property (run_q && frame_done |=> !run_q && !sleep_return_o)
    else $error("Serial access did not stop the timer.");
  reserved_zero_a: assert property (pin_q[7] == 1'b0 && pin_q[0] == 1'b0 && tmr_q[6:3] == 4'h0
    && wake_q[0] == 1'b0 && sdoc_q[7:1] == 7'h00)
    else $error("Reserved bit set.");
  sdo_share_a: assert property (!active && sdoc_q[pwc_pkg::BIT_SDO_MODE] && io_s2_q |=> sdo_oe_o)
    else $error("Interrupt sharing not driving the pin.");
endmodule : pwc_regs

// *** verification/pwc_host.sv ***
// Host serial master model that clocks mode 0 frames into the register bank.
`timescale 1ns/1ps
module pwc_host (
  input wire logic clk_i, // System clock.
  input wire logic sdo_i, // Serial data out from the device.
  output logic sclk_o, // Serial clock, low between frames.
  output logic cs_n_o, // Chip select, active low.
  output logic sdi_o // Serial data to the device.
);
  localparam int HALF = 6;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Sends header and data bytes, most significant bit first, and returns the byte seen on data out.
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] s;
    s = {a, w, d};
    q = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_o <= s[i];
      repeat (HALF - 1) @(posedge clk_i);
      @(negedge clk_i);
      if (i < 8) begin
        q[i] = sdo_i;
      end
      @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // A released data line must not keep showing the last bit.
    sdi_o <= ~s[0];
    repeat (HALF) @(posedge clk_i);
  endtask : frame
endmodule : pwc_host

// *** verification/test_pin_and_wake_error_config.sv ***
// Self-checking testbench for the pin and wake error configuration registers.
`timescale 1ns/1ps
module test_pin_and_wake_error_config;
  logic clk_i, rst_i, sclk, cs_n, sdi, io, int_n, silence;
  logic sdo, sdo_oe, sup, fb, wmax, run, slp;
  logic [2:0] pl;
  logic [7:0] q;
  int errors, samples_checked;
  pwc_regs #(.WAKE_TIMER_CYCLES(400)) pwc_regs_i (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .io_supply_pin_i(io), .interrupt_out_n_i(int_n), .wd_good_trigger_i(pl[0]),
    .fallback_fault_i(pl[1]), .wake_exit_i(pl[2]), .bus_silence_flag_i(silence), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .supply_enable_output_o(sup), .fallback_output_o(fb),
    .wake_max_pulse_check_off_o(wmax), .wake_timer_running_o(run), .sleep_return_o(slp));
  pwc_host pwc_host_i (.clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wt
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    pwc_host_i.frame(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    pwc_host_i.frame(a, 1'b0, 8'h00, d);
  endtask : rd
  task automatic pulse(input int b, input int k);
    repeat (k) begin
      @(posedge clk_i);
      pl[b] <= 1'b1;
      @(posedge clk_i);
      pl[b] <= 1'b0;
      wt(3);
    end
  endtask : pulse
  // Reports whether a return-to-sleep pulse shows within n cycles.
  task automatic watch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      s = s | (slp === 1'b1);
    end
  endtask : watch
  task automatic t_power;
    logic s;
    wt(1);
    chk("timer at power-up", 8'h01, run);
    watch(1000, s);
    chk("sleep return", 8'h01, s);
    chk("timer stopped", 8'h00, run);
    $display("power-up timer test done");
  endtask : t_power
  task automatic t_regs;
    logic [6:0] a [5] = '{pwc_pkg::ADDR_PIN_CFG, pwc_pkg::ADDR_WAKE_CFG, pwc_pkg::ADDR_TIMER_CFG,
      pwc_pkg::ADDR_SDO_CFG, 7'h20};
    logic [7:0] m [5] = '{8'h7C, 8'h02, 8'h84, 8'h01, 8'h00};
    logic [7:0] r;
    for (int i = 0; i < 5; i++) begin
      rd(a[i], r);
      chk("reset value", (i == 2) ? 8'h04 : 8'h00, r);
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        wr(a[i], (p == 0) ? 8'hFF : 8'h00);
      end
      wt(2);
      chk("wake check off", {7'h00, p == 0}, wmax);
      for (int i = 0; i < 5; i++) begin
        rd(a[i], r);
        chk("readback", (p == 0) ? m[i] : 8'h00, r);
      end
    end
    $display("register access test done");
  endtask : t_regs
  task automatic t_pins;
    logic [7:0] v [5] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h2C};
    logic [1:0] e [5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
    for (int i = 0; i < 5; i++) begin
      wr(pwc_pkg::ADDR_PIN_CFG, v[i]);
      pulse(1, 1);
      chk("supply enable out", e[i][1], sup);
      chk("fallback out", e[i][0], fb);
    end
    $display("pin function test done");
  endtask : t_pins
  task automatic t_methods;
    int need;
    for (int m = 0; m < 4; m++) begin
      need = (m == 0) ? 3 : (m == 1) ? 1 : 4;
      wr(pwc_pkg::ADDR_PIN_CFG, 8'h20 | 8'(m << 2));
      pulse(1, 1);
      for (int k = 1; k <= 3; k++) begin
        pulse(0, 1);
        chk("fallback after trigger", {7'h00, k < need}, fb);
      end
    end
    wr(pwc_pkg::ADDR_PIN_CFG, 8'h28);
    wt(2);
    chk("fallback kept on method change", 8'h01, fb);
    wr(pwc_pkg::ADDR_PIN_CFG, 8'h2A);
    wt(2);
    chk("fallback after strobe", 8'h00, fb);
    rd(pwc_pkg::ADDR_PIN_CFG, q);
    chk("strobe readback", 8'h28, q);
    $display("fallback turn-off test done");
  endtask : t_methods
  task automatic t_timer;
    logic [7:0] c [3] = '{8'h00, 8'h04, 8'h80};
    logic [1:0] e [3] = '{2'h2, 2'h3, 2'h0};
    logic s;
    for (int i = 0; i < 3; i++) begin
      wr(pwc_pkg::ADDR_TIMER_CFG, c[i]);
      pulse(2, 1);
      chk("timer after wake", e[i][1], run);
      watch(600, s);
      chk("sleep return", e[i][0], s);
    end
    silence <= 1'b1;
    watch(600, s);
    chk("timer on silence", 8'h00, s);
    wr(pwc_pkg::ADDR_TIMER_CFG, 8'h00);
    pulse(2, 1);
    watch(600, s);
    chk("sleep with silence flag", 8'h01, s);
    silence <= 1'b0;
    wr(pwc_pkg::ADDR_TIMER_CFG, 8'h04);
    pulse(2, 1);
    rd(pwc_pkg::ADDR_PIN_CFG, q);
    wt(2);
    chk("timer after access", 8'h00, run);
    watch(600, s);
    chk("no sleep after access", 8'h00, s);
    $display("sleep-wake-error timer test done");
  endtask : t_timer
  task automatic t_sdo;
    wr(pwc_pkg::ADDR_SDO_CFG, 8'h01);
    for (int k = 0; k < 2; k++) begin
      int_n <= k[0];
      wt(4);
      chk("shared pin enable", 8'h01, sdo_oe);
      chk("shared pin level", {7'h00, k[0]}, sdo);
    end
    wr(pwc_pkg::ADDR_SDO_CFG, 8'h00);
    wt(4);
    chk("serial out only", 8'h00, sdo_oe);
    io <= 1'b0;
    wr(pwc_pkg::ADDR_WAKE_CFG, 8'h02);
    io <= 1'b1;
    rd(pwc_pkg::ADDR_WAKE_CFG, q);
    chk("write without supply", 8'h00, q);
    $display("shared pin test done");
  endtask : t_sdo
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    io = 1'b1;
    int_n = 1'b1;
    pl = 3'h0;
    silence = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_regs();
    t_pins();
    t_methods();
    t_timer();
    t_sdo();
    finish_test();
  end
endmodule : test_pin_and_wake_error_config
